/* include/dci_consts.svh */
`ifndef DCI_CONSTS_SVH
`define DCI_CONSTS_SVH

// request address fields
`define DCI_WORD_LSB 2
`define DCI_WORD_MSB 3
`define DCI_HALF_BIT 4
`define DCI_IDX_LSB 5
`define DCI_IDX_MSB 17
`define DCI_TAG_LSB 10
`define DCI_TAG_MSB 31
`define DCI_WHB_LSB 4
`define DCI_WHB_MSB 17

// associativity codes
`define DCI_ASSOC_DIRECT 2'h0
`define DCI_ASSOC_TWO 2'h1
`define DCI_ASSOC_FOUR 2'h2

// size codes: none, then 4 KB doubling up to the last code
`define DCI_SIZE_NONE 4'h0
`define DCI_SIZE_MIN 4'h3
`define DCI_SIZE_MAX 4'hb

// way masks and set clamps
`define DCI_MASK_NONE 4'h0
`define DCI_MASK_ONE 4'h1
`define DCI_MASK_TWO 4'h3
`define DCI_MASK_FOUR 4'hf
`define DCI_CLAMP_ONE 2'h0
`define DCI_CLAMP_TWO 2'h1
`define DCI_CLAMP_FOUR 2'h3

// full byte enable and reset values
`define DCI_BE_ALL 4'hf
`define DCI_RST_ADDR 32'h0000_0000
`define DCI_RST_WORD 32'h0000_0000

// cycles from request taken to response
`define DCI_RSP_LATENCY 3

`endif

/* include/dci_pkg.sv */
package dci_pkg;

	typedef enum logic [2:0] {
		DCI_IDLE = 3'b000,
		DCI_ACCESS = 3'b001,
		DCI_COMPARE = 3'b010,
		DCI_MWAIT = 3'b011,
		DCI_MCAP = 3'b100
	} dci_state_type;

	typedef enum logic [3:0] {
		DCI_CMD_READ = 4'b0000,
		DCI_CMD_WRITE = 4'b0001,
		DCI_CMD_FILL = 4'b0010,
		DCI_CMD_FILL_LAST = 4'b0011,
		DCI_CMD_FLUSH_ALL = 4'b0100,
		DCI_CMD_FLUSH_ADDR = 4'b0101,
		DCI_CMD_FLUSH_INDEX = 4'b0110,
		DCI_CMD_TAG_WRITE = 4'b0111,
		DCI_CMD_CLEAR_DIRTY = 4'b1000
	} dci_cmd_type;

	typedef logic [3:0][31:0] dci_word_vec_type;
	typedef logic [3:0][3:0] dci_be_vec_type;

endpackage : dci_pkg

/* include/dci_match_if.sv */
`timescale 1ns/1ns
// carries tag lookup operands to the compare unit and the hit back
interface dci_match_if;
	dci_pkg::dci_word_vec_type tag_rd;
	logic [3:0] valid;
	logic [21:0] tag_ref;
	logic [3:0] way_mask;
	logic [3:0] hit;
	logic [1:0] hit_set;
	logic any_hit;

	modport ctl (
		output tag_rd, valid, tag_ref, way_mask,
		input hit, hit_set, any_hit
	);
	modport unit (
		input tag_rd, valid, tag_ref, way_mask,
		output hit, hit_set, any_hit
	);
endinterface : dci_match_if

/* rtl/dci_tag_match.sv */
`timescale 1ns/1ns
module dci_tag_match (
	dci_match_if.unit m
);

	// only ways that exist and hold a valid line may hit
	always_comb begin
		m.hit = 4'h0;
		m.hit_set = 2'h0;
		for (int s = 0; s < 4; s++) begin
			if (m.way_mask[s] && m.valid[s] &&
				m.tag_rd[s][21:0] == m.tag_ref) begin
				m.hit[s] = 1'b1;
				m.hit_set = 2'(s);
			end
		end
	end

	assign m.any_hit = |m.hit;

endmodule : dci_tag_match

/* rtl/dci_cache_ram_ctl.sv */
`timescale 1ns/1ns
`include "dci_consts.svh"
module dci_cache_ram_ctl (
	input wire logic clk_i,
	input wire logic nrst_i,
	// configuration
	input wire logic [1:0] associativity_select_i,
	input wire logic [3:0] cache_size_select_i,
	input wire logic write_back_cfg_i,
	// request and response
	input wire logic req_valid_i,
	input wire dci_pkg::dci_cmd_type req_cmd_i,
	input wire logic [31:0] req_addr_i,
	input wire logic [31:0] req_wdata_i,
	input wire logic [3:0] req_byte_en_i,
	input wire logic [1:0] req_set_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic rsp_hit_o,
	output logic [31:0] rsp_rdata_o,
	output logic [1:0] rsp_dirty_o,
	// data and tag RAMs
	input wire dci_pkg::dci_word_vec_type lower_ram_read_data_i,
	input wire dci_pkg::dci_word_vec_type upper_ram_read_data_i,
	input wire dci_pkg::dci_word_vec_type tag_read_data_i,
	output logic [14:0] lower_ram_word_address_o,
	output logic [14:0] upper_ram_word_address_o,
	output logic [32:0] cache_write_data_o,
	output logic [3:0] lower_ram_clock_enable_o,
	output logic [3:0] upper_ram_clock_enable_o,
	output dci_pkg::dci_be_vec_type lower_byte_write_enable_o,
	output dci_pkg::dci_be_vec_type upper_byte_write_enable_o,
	output logic [12:0] tag_ram_address_o,
	output logic [21:0] tag_write_data_o,
	output logic [3:0] tag_ram_clock_enable_o,
	output logic [3:0] tag_ram_write_enable_o,
	// valid and dirty bit modules
	input wire logic [3:0] per_set_valid_in_i,
	input wire logic victim_upper_dirty_i,
	input wire logic victim_lower_dirty_i,
	input wire logic captured_upper_dirty_i,
	input wire logic captured_lower_dirty_i,
	output logic valid_write_enable_o,
	output logic valid_set_value_o,
	output logic line_dirty_clear_o,
	output logic maint_dirty_clear_pulse_o,
	output logic maint_flush_by_address_o,
	output logic maint_flush_all_o,
	output logic maint_flush_by_index_o,
	output logic maint_tag_write_set_valid_o,
	output logic [3:0] per_set_hit_o,
	output logic [12:0] delayed_line_index_o,
	output logic victim_line_index_o,
	output logic [1:0] victim_set_pointer_o,
	output logic write_back_policy_o,
	output logic [13:0] write_hit_buffer_address_o,
	output logic write_hit_ram_write_enable_o,
	output logic [3:0] write_hit_set_vector_o
);

	// highest set number that exists for an associativity code
	function automatic logic [1:0] dci_set_clamp(input logic [1:0] a);
		unique case (a)
			`DCI_ASSOC_TWO: return `DCI_CLAMP_TWO;
			`DCI_ASSOC_FOUR: return `DCI_CLAMP_FOUR;
			default: return `DCI_CLAMP_ONE;
		endcase
	endfunction : dci_set_clamp

	// sets in use; a size code outside the table means no cache
	function automatic logic [3:0] dci_way_mask(input logic [1:0] a,
		input logic [3:0] sz);
		if (sz < `DCI_SIZE_MIN || sz > `DCI_SIZE_MAX)
			return `DCI_MASK_NONE;
		unique case (dci_set_clamp(a))
			`DCI_CLAMP_TWO: return `DCI_MASK_TWO;
			`DCI_CLAMP_FOUR: return `DCI_MASK_FOUR;
			default: return `DCI_MASK_ONE;
		endcase
	endfunction : dci_way_mask

	// reset released through two flops
	logic [1:0] rst_sync_r;
	logic rst_n_q;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n_q = rst_sync_r[1];

	dci_pkg::dci_state_type state_r, state_nxt;
	dci_pkg::dci_cmd_type cmd_r, cmd_nxt;
	logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt;
	logic [3:0] be_r, be_nxt;
	logic [1:0] rr_r, rr_nxt, vptr_r, vptr_nxt;
	logic [14:0] ram_addr_r, ram_addr_nxt;
	logic [12:0] idx_r, idx_nxt;
	logic [21:0] tag_wd_r, tag_wd_nxt;
	logic [32:0] wd_out_r, wd_out_nxt;
	logic [3:0] lo_en_r, lo_en_nxt, up_en_r, up_en_nxt;
	logic [3:0] tag_en_r, tag_en_nxt, tag_we_r, tag_we_nxt;
	dci_pkg::dci_be_vec_type lo_we_r, lo_we_nxt, up_we_r, up_we_nxt;
	logic vld_we_r, vld_we_nxt, vld_set_r, vld_set_nxt;
	logic dclr_r, dclr_nxt, mclr_r, mclr_nxt, mfa_r, mfa_nxt;
	logic mfall_r, mfall_nxt, mfi_r, mfi_nxt, mtw_r, mtw_nxt;
	logic vidx_r, vidx_nxt, wb_r, wh_we_r, wh_we_nxt;
	logic [3:0] hitv_r, hitv_nxt, wh_set_r, wh_set_nxt;
	logic [13:0] wh_addr_r, wh_addr_nxt;
	logic rsp_v_r, rsp_v_nxt, rsp_hit_r, rsp_hit_nxt;
	logic [31:0] rsp_rd_r, rsp_rd_nxt;
	logic [1:0] rsp_dirty_r, rsp_dirty_nxt;
	logic [3:0] act_mask;
	logic [3:0] fill_way;
	logic [3:0] hit_way;

	dci_match_if mif ();
	dci_tag_match u_match (
		.m(mif.unit)
	);

	// tag reference comes from the request held since it was taken; tags and valid bits from the RAMs
	assign act_mask = dci_way_mask(associativity_select_i,
		cache_size_select_i);
	assign mif.tag_rd = tag_read_data_i;
	assign mif.valid = per_set_valid_in_i;
	assign mif.tag_ref = addr_r[`DCI_TAG_MSB:`DCI_TAG_LSB];
	assign mif.way_mask = act_mask;
	assign fill_way = act_mask & (4'h1 << rr_r);
	assign hit_way = mif.hit;
	assign req_ready_o = rst_n_q && state_r == dci_pkg::DCI_IDLE;

	// next values for the sequencer and every registered RAM control
	always_comb begin
		state_nxt = state_r;
		cmd_nxt = cmd_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		be_nxt = be_r;
		rr_nxt = rr_r;
		vptr_nxt = vptr_r;
		ram_addr_nxt = ram_addr_r;
		idx_nxt = idx_r;
		tag_wd_nxt = tag_wd_r;
		wd_out_nxt = wd_out_r;
		vidx_nxt = vidx_r;
		wh_addr_nxt = wh_addr_r;
		rsp_hit_nxt = rsp_hit_r;
		rsp_rd_nxt = rsp_rd_r;
		rsp_dirty_nxt = rsp_dirty_r;
		// enables and strobes fall back to low each cycle
		lo_en_nxt = 4'h0;
		up_en_nxt = 4'h0;
		tag_en_nxt = 4'h0;
		tag_we_nxt = 4'h0;
		lo_we_nxt = '0;
		up_we_nxt = '0;
		vld_we_nxt = 1'b0;
		vld_set_nxt = 1'b0;
		dclr_nxt = 1'b0;
		mclr_nxt = 1'b0;
		mfa_nxt = 1'b0;
		mfall_nxt = 1'b0;
		mfi_nxt = 1'b0;
		mtw_nxt = 1'b0;
		wh_we_nxt = 1'b0;
		wh_set_nxt = 4'h0;
		hitv_nxt = 4'h0;
		rsp_v_nxt = 1'b0;
		unique case (state_r)
			dci_pkg::DCI_IDLE: begin
				if (req_valid_i && rst_n_q) begin
					cmd_nxt = req_cmd_i;
					addr_nxt = req_addr_i;
					wdata_nxt = req_wdata_i;
					be_nxt = req_byte_en_i;
					idx_nxt = req_addr_i[`DCI_IDX_MSB:`DCI_IDX_LSB];
					ram_addr_nxt = {req_addr_i[`DCI_IDX_MSB:`DCI_IDX_LSB],
						req_addr_i[`DCI_WORD_MSB:`DCI_WORD_LSB]};
					tag_wd_nxt = req_addr_i[`DCI_TAG_MSB:`DCI_TAG_LSB];
					wd_out_nxt = {^req_wdata_i, req_wdata_i};
					vidx_nxt = req_addr_i[`DCI_HALF_BIT];
					vptr_nxt = req_set_i & dci_set_clamp(associativity_select_i);
					state_nxt = dci_pkg::DCI_MWAIT;
					unique case (req_cmd_i)
						dci_pkg::DCI_CMD_READ, dci_pkg::DCI_CMD_WRITE,
						dci_pkg::DCI_CMD_FLUSH_ADDR: begin
							// read only the half that holds the word
							tag_en_nxt = act_mask;
							if (req_addr_i[`DCI_HALF_BIT])
								up_en_nxt = act_mask;
							else
								lo_en_nxt = act_mask;
							state_nxt = dci_pkg::DCI_ACCESS;
						end
						dci_pkg::DCI_CMD_FILL, dci_pkg::DCI_CMD_FILL_LAST: begin
							vptr_nxt = rr_r;
							for (int s = 0; s < 4; s++) begin
								if (fill_way[s] && req_addr_i[`DCI_HALF_BIT])
									up_we_nxt[s] = `DCI_BE_ALL;
								if (fill_way[s] && !req_addr_i[`DCI_HALF_BIT])
									lo_we_nxt[s] = `DCI_BE_ALL;
							end
							if (req_addr_i[`DCI_HALF_BIT])
								up_en_nxt = fill_way;
							else
								lo_en_nxt = fill_way;
							if (req_cmd_i == dci_pkg::DCI_CMD_FILL_LAST) begin
								// last word: tag, valid and dirty close the line
								tag_en_nxt = fill_way;
								tag_we_nxt = fill_way;
								vld_we_nxt = |fill_way;
								vld_set_nxt = |fill_way;
								dclr_nxt = |fill_way;
								rr_nxt = 2'(rr_r + 2'h1) &
									dci_set_clamp(associativity_select_i);
							end
						end
						dci_pkg::DCI_CMD_FLUSH_ALL: mfall_nxt = 1'b1;
						dci_pkg::DCI_CMD_FLUSH_INDEX: mfi_nxt = 1'b1;
						dci_pkg::DCI_CMD_TAG_WRITE: begin
							mtw_nxt = 1'b1;
							tag_en_nxt = act_mask & (4'h1 << vptr_nxt);
							tag_we_nxt = act_mask & (4'h1 << vptr_nxt);
						end
						dci_pkg::DCI_CMD_CLEAR_DIRTY: mclr_nxt = 1'b1;
						default: cmd_nxt = dci_pkg::DCI_CMD_READ;
					endcase
				end
			end
			dci_pkg::DCI_ACCESS: state_nxt = dci_pkg::DCI_COMPARE;
			dci_pkg::DCI_COMPARE: begin
				// RAM data and tags are back; answer and act on the hit
				rsp_v_nxt = 1'b1;
				rsp_hit_nxt = mif.any_hit;
				rsp_dirty_nxt = 2'h0;
				hitv_nxt = hit_way;
				rsp_rd_nxt = addr_r[`DCI_HALF_BIT] ?
					upper_ram_read_data_i[mif.hit_set] :
					lower_ram_read_data_i[mif.hit_set];
				if (cmd_r == dci_pkg::DCI_CMD_WRITE && mif.any_hit) begin
					for (int s = 0; s < 4; s++) begin
						if (hit_way[s] && addr_r[`DCI_HALF_BIT])
							up_we_nxt[s] = be_r;
						if (hit_way[s] && !addr_r[`DCI_HALF_BIT])
							lo_we_nxt[s] = be_r;
					end
					if (addr_r[`DCI_HALF_BIT])
						up_en_nxt = hit_way;
					else
						lo_en_nxt = hit_way;
					wh_we_nxt = 1'b1;
					// dirty marking is withheld in write-through
					wh_set_nxt = write_back_cfg_i ? hit_way : 4'h0;
					wh_addr_nxt = addr_r[`DCI_WHB_MSB:`DCI_WHB_LSB];
				end
				if (cmd_r == dci_pkg::DCI_CMD_FLUSH_ADDR && mif.any_hit) begin
					mfa_nxt = 1'b1;
					vptr_nxt = mif.hit_set;
				end
				state_nxt = dci_pkg::DCI_IDLE;
			end
			dci_pkg::DCI_MWAIT: state_nxt = dci_pkg::DCI_MCAP;
			dci_pkg::DCI_MCAP: begin
				// captured inputs lag the victim ones by a clock
				rsp_v_nxt = 1'b1;
				rsp_hit_nxt = 1'b0;
				rsp_dirty_nxt = {captured_upper_dirty_i,
					captured_lower_dirty_i};
				state_nxt = dci_pkg::DCI_IDLE;
			end
			default: state_nxt = dci_pkg::DCI_IDLE;
		endcase
	end

	// register stage; all RAM-side outputs come straight from here
	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_r <= dci_pkg::DCI_IDLE;
			cmd_r <= dci_pkg::DCI_CMD_READ;
			addr_r <= `DCI_RST_ADDR;
			wdata_r <= `DCI_RST_WORD;
			be_r <= 4'h0;
			{rr_r, vptr_r} <= 4'h0;
			ram_addr_r <= 15'h0000;
			idx_r <= 13'h0000;
			tag_wd_r <= 22'h00_0000;
			wd_out_r <= 33'h0_0000_0000;
			{lo_en_r, up_en_r, tag_en_r, tag_we_r} <= 16'h0000;
			lo_we_r <= '0;
			up_we_r <= '0;
			{vld_we_r, vld_set_r, dclr_r, mclr_r} <= 4'h0;
			{mfa_r, mfall_r, mfi_r, mtw_r} <= 4'h0;
			{vidx_r, wb_r, wh_we_r, rsp_v_r, rsp_hit_r} <= 5'h00;
			{hitv_r, wh_set_r} <= 8'h00;
			wh_addr_r <= 14'h0000;
			rsp_rd_r <= `DCI_RST_WORD;
			rsp_dirty_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			cmd_r <= cmd_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			be_r <= be_nxt;
			{rr_r, vptr_r} <= {rr_nxt, vptr_nxt};
			ram_addr_r <= ram_addr_nxt;
			idx_r <= idx_nxt;
			tag_wd_r <= tag_wd_nxt;
			wd_out_r <= wd_out_nxt;
			{lo_en_r, up_en_r} <= {lo_en_nxt, up_en_nxt};
			{tag_en_r, tag_we_r} <= {tag_en_nxt, tag_we_nxt};
			lo_we_r <= lo_we_nxt;
			up_we_r <= up_we_nxt;
			{vld_we_r, vld_set_r, dclr_r, mclr_r} <=
				{vld_we_nxt, vld_set_nxt, dclr_nxt, mclr_nxt};
			{mfa_r, mfall_r, mfi_r, mtw_r} <=
				{mfa_nxt, mfall_nxt, mfi_nxt, mtw_nxt};
			{vidx_r, wb_r, wh_we_r} <= {vidx_nxt, write_back_cfg_i, wh_we_nxt};
			{rsp_v_r, rsp_hit_r} <= {rsp_v_nxt, rsp_hit_nxt};
			{hitv_r, wh_set_r} <= {hitv_nxt, wh_set_nxt};
			wh_addr_r <= wh_addr_nxt;
			rsp_rd_r <= rsp_rd_nxt;
			rsp_dirty_r <= rsp_dirty_nxt;
		end
	end

	// output wiring
	assign lower_ram_word_address_o = ram_addr_r;
	assign upper_ram_word_address_o = ram_addr_r;
	assign cache_write_data_o = wd_out_r;
	assign {lower_ram_clock_enable_o, upper_ram_clock_enable_o} =
		{lo_en_r, up_en_r};
	assign lower_byte_write_enable_o = lo_we_r;
	assign upper_byte_write_enable_o = up_we_r;
	assign tag_ram_address_o = idx_r;
	assign delayed_line_index_o = idx_r;
	assign tag_write_data_o = tag_wd_r;
	assign {tag_ram_clock_enable_o, tag_ram_write_enable_o} =
		{tag_en_r, tag_we_r};
	assign {valid_write_enable_o, valid_set_value_o} = {vld_we_r, vld_set_r};
	assign line_dirty_clear_o = dclr_r;
	assign maint_dirty_clear_pulse_o = mclr_r;
	assign maint_flush_by_address_o = mfa_r;
	assign maint_flush_all_o = mfall_r;
	assign maint_flush_by_index_o = mfi_r;
	assign maint_tag_write_set_valid_o = mtw_r;
	assign per_set_hit_o = hitv_r;
	assign victim_line_index_o = vidx_r;
	assign victim_set_pointer_o = vptr_r;
	assign write_back_policy_o = wb_r;
	assign write_hit_buffer_address_o = wh_addr_r;
	assign write_hit_ram_write_enable_o = wh_we_r;
	assign write_hit_set_vector_o = wh_set_r;
	assign {rsp_valid_o, rsp_hit_o} = {rsp_v_r, rsp_hit_r};
	assign rsp_rdata_o = rsp_rd_r;
	assign rsp_dirty_o = rsp_dirty_r;

	// checks on the registered outputs
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_q);

	fill_close_a: assert property (line_dirty_clear_o |->
		valid_write_enable_o && valid_set_value_o && |tag_ram_write_enable_o)
		else $error("dirty clear without line fill");
	mclr_pulse_a: assert property (maint_dirty_clear_pulse_o |=>
		!maint_dirty_clear_pulse_o)
		else $error("dirty clear pulse longer than one cycle");
	flush_addr_a: assert property (maint_flush_by_address_o |->
		per_set_hit_o[victim_set_pointer_o] && rsp_hit_o)
		else $error("flush by address without hit");
	flush_all_a: assert property (req_valid_i && req_ready_o &&
		req_cmd_i == dci_pkg::DCI_CMD_FLUSH_ALL |=> maint_flush_all_o ##1
		!maint_flush_all_o)
		else $error("flush all not a single pulse");
	ram_addr_a: assert property (
		lower_ram_word_address_o == upper_ram_word_address_o)
		else $error("lower and upper word address differ");
	hit_onehot_a: assert property ($onehot0(per_set_hit_o))
		else $error("more than one set hit");
	way_gate_a: assert property (((lower_ram_clock_enable_o |
		upper_ram_clock_enable_o | tag_ram_clock_enable_o) &
		~$past(act_mask)) == 4'h0)
		else $error("enable on absent set");
	wh_vector_a: assert property (write_hit_ram_write_enable_o |->
		write_hit_set_vector_o == (write_back_policy_o ? per_set_hit_o : 4'h0))
		else $error("write hit set vector wrong");
	wt_dirty_a: assert property (!write_back_policy_o |->
		write_hit_set_vector_o == 4'h0)
		else $error("dirty set in write-through");
	rsp_time_a: assert property (req_valid_i && req_ready_o |->
		##3 rsp_valid_o)
		else $error("response not three cycles after request");

	read_hit_c: cover property (rsp_valid_o && rsp_hit_o);
	write_hit_c: cover property (write_hit_ram_write_enable_o &&
		write_back_policy_o);
	flush_hit_c: cover property (maint_flush_by_address_o);
	fill_last_c: cover property (line_dirty_clear_o);

endmodule : dci_cache_ram_ctl

/* sim/dci_ram_model.sv */
`timescale 1ns/1ns
// behavioural storage behind the controller: data, tag, valid, dirty bits
module dci_ram_model (
	input wire logic clk_i,
	input wire logic [14:0] lower_ram_word_address_o,
	input wire logic [14:0] upper_ram_word_address_o,
	input wire logic [32:0] cache_write_data_o,
	input wire dci_pkg::dci_be_vec_type lower_byte_write_enable_o,
	input wire dci_pkg::dci_be_vec_type upper_byte_write_enable_o,
	input wire logic [12:0] tag_ram_address_o,
	input wire logic [21:0] tag_write_data_o,
	input wire logic [3:0] tag_ram_write_enable_o,
	input wire logic valid_write_enable_o,
	input wire logic valid_set_value_o,
	input wire logic line_dirty_clear_o,
	input wire logic maint_dirty_clear_pulse_o,
	input wire logic maint_flush_by_address_o,
	input wire logic maint_flush_all_o,
	input wire logic maint_flush_by_index_o,
	input wire logic maint_tag_write_set_valid_o,
	input wire logic [12:0] delayed_line_index_o,
	input wire logic [1:0] victim_set_pointer_o,
	input wire logic [13:0] write_hit_buffer_address_o,
	input wire logic write_hit_ram_write_enable_o,
	input wire logic [3:0] write_hit_set_vector_o,
	output dci_pkg::dci_word_vec_type lower_ram_read_data_i,
	output dci_pkg::dci_word_vec_type upper_ram_read_data_i,
	output dci_pkg::dci_word_vec_type tag_read_data_i,
	output logic [3:0] per_set_valid_in_i,
	output logic victim_upper_dirty_i,
	output logic victim_lower_dirty_i,
	output logic captured_upper_dirty_i,
	output logic captured_lower_dirty_i
);
	// shallow data and tag arrays: only the low index bits matter in these tests
	logic [31:0] lo_mem [4][256] = '{default: '0};
	logic [31:0] up_mem [4][256] = '{default: '0};
	logic [21:0] tag_mem [4][256] = '{default: '0};
	logic [3:0] vbits [8192];
	logic [1:0] dbits [4][8192] = '{default: '0};
	logic [7:0] la, ua, ta;
	logic [12:0] vi, wi;
	logic [1:0] vp;
	// address slices and the bits picked by the delayed index
	assign la = lower_ram_word_address_o[7:0];
	assign ua = upper_ram_word_address_o[7:0];
	assign ta = tag_ram_address_o[7:0];
	assign vi = delayed_line_index_o;
	assign vp = victim_set_pointer_o;
	assign wi = write_hit_buffer_address_o[13:1];
	assign per_set_valid_in_i = vbits[vi];
	assign {victim_upper_dirty_i, victim_lower_dirty_i} = dbits[vp][vi];
	// clock enables ignored on purpose: results must not depend on them
	always @(posedge clk_i) begin
		{captured_upper_dirty_i, captured_lower_dirty_i} <= dbits[vp][vi];
		for (int s = 0; s < 4; s++) begin
			lower_ram_read_data_i[s] <= lo_mem[s][la];
			upper_ram_read_data_i[s] <= up_mem[s][ua];
			tag_read_data_i[s] <= {10'h000, tag_mem[s][ta]};
			if (tag_ram_write_enable_o[s])
				tag_mem[s][ta] <= tag_write_data_o;
			for (int b = 0; b < 4; b++) begin
				if (lower_byte_write_enable_o[s][b])
					lo_mem[s][la][b*8+:8] <= cache_write_data_o[b*8+:8];
				if (upper_byte_write_enable_o[s][b])
					up_mem[s][ua][b*8+:8] <= cache_write_data_o[b*8+:8];
			end
			if (write_hit_ram_write_enable_o && write_hit_set_vector_o[s])
				dbits[s][wi][write_hit_buffer_address_o[0]] <= 1'b1;
		end
		if (maint_flush_by_index_o || maint_flush_by_address_o)
			vbits[vi][vp] <= 1'b0;
		if (maint_tag_write_set_valid_o)
			vbits[vi][vp] <= 1'b1;
		if (valid_write_enable_o)
			vbits[vi][vp] <= valid_set_value_o;
		if (line_dirty_clear_o || maint_dirty_clear_pulse_o)
			dbits[vp][vi] <= 2'h0;
		if (maint_flush_all_o)
			for (int i = 0; i < 8192; i++)
				vbits[i] <= 4'h0;
	end
endmodule : dci_ram_model

/* sim/dci_cache_ram_ctl_bench.sv */
`timescale 1ns/1ns
// directed bench: one task per scenario, storage modelled behind the pins
module dci_cache_ram_ctl_bench;
	localparam logic [31:0] A = 32'h0000_0464;
	localparam logic [31:0] B = 32'h0080_0464;
	localparam logic [31:0] D = 32'h1234_5678;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [1:0] associativity_select_i = 2'h0;
	logic [3:0] cache_size_select_i = 4'h3;
	logic write_back_cfg_i = 1'b1;
	logic req_valid_i = 1'b0;
	dci_pkg::dci_cmd_type req_cmd_i = dci_pkg::DCI_CMD_READ;
	logic [31:0] req_addr_i = 32'h0000_0000;
	logic [31:0] req_wdata_i = 32'h0000_0000;
	logic [3:0] req_byte_en_i = 4'h0;
	logic [1:0] req_set_i = 2'h0;
	logic req_ready_o, rsp_valid_o, rsp_hit_o, valid_write_enable_o;
	logic valid_set_value_o, line_dirty_clear_o, maint_dirty_clear_pulse_o;
	logic maint_flush_by_address_o, maint_flush_all_o, maint_flush_by_index_o;
	logic maint_tag_write_set_valid_o, victim_line_index_o;
	logic write_back_policy_o, write_hit_ram_write_enable_o;
	logic victim_upper_dirty_i, victim_lower_dirty_i;
	logic captured_upper_dirty_i, captured_lower_dirty_i;
	logic [31:0] rsp_rdata_o;
	logic [32:0] cache_write_data_o;
	logic [1:0] rsp_dirty_o, victim_set_pointer_o;
	logic [14:0] lower_ram_word_address_o, upper_ram_word_address_o, s_la;
	logic [12:0] tag_ram_address_o, delayed_line_index_o, s_ta;
	logic [21:0] tag_write_data_o;
	logic [13:0] write_hit_buffer_address_o;
	logic [3:0] lower_ram_clock_enable_o, upper_ram_clock_enable_o;
	logic [3:0] tag_ram_clock_enable_o, tag_ram_write_enable_o;
	logic [3:0] per_set_valid_in_i, per_set_hit_o, write_hit_set_vector_o;
	dci_pkg::dci_word_vec_type lower_ram_read_data_i, upper_ram_read_data_i;
	dci_pkg::dci_word_vec_type tag_read_data_i;
	dci_pkg::dci_be_vec_type lower_byte_write_enable_o;
	dci_pkg::dci_be_vec_type upper_byte_write_enable_o;
	logic [3:0] s_en, s_ten, s_twe, s_hit, s_whv, s_lwe0;
	logic [4:0] s_mnt;
	logic s_vwe, s_ldc, s_whe;
	int errors = 0;
	int checks_done = 0;
	int lat;

	dci_cache_ram_ctl dut (.*);
	dci_ram_model m (.*);

	always #20 clk_i = ~clk_i;

	// strobes last one cycle, so gather them between operations
	always @(posedge clk_i) begin
		s_en |= lower_ram_clock_enable_o | upper_ram_clock_enable_o;
		s_ten |= tag_ram_clock_enable_o;
		s_twe |= tag_ram_write_enable_o;
		s_hit |= per_set_hit_o;
		s_whv |= write_hit_set_vector_o;
		s_lwe0 |= lower_byte_write_enable_o[0];
		s_mnt |= {maint_dirty_clear_pulse_o, maint_flush_all_o,
			maint_flush_by_index_o, maint_tag_write_set_valid_o,
			maint_flush_by_address_o};
		s_vwe |= valid_write_enable_o & valid_set_value_o;
		s_ldc |= line_dirty_clear_o;
		s_whe |= write_hit_ram_write_enable_o;
		if (|lower_ram_clock_enable_o)
			s_la = lower_ram_word_address_o;
		if (|tag_ram_clock_enable_o)
			s_ta = tag_ram_address_o;
	end

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one request, held until taken, then wait for its answer
	task automatic op(input dci_pkg::dci_cmd_type c, input logic [31:0] a,
		input logic [31:0] d = 0, input logic [3:0] be = 0,
		input logic [1:0] st = 0);
		{s_en, s_ten, s_twe, s_hit, s_whv, s_lwe0} = '0;
		{s_mnt, s_vwe, s_ldc, s_whe} = '0;
		req_cmd_i = c;
		req_addr_i = a;
		req_wdata_i = d;
		req_byte_en_i = be;
		req_set_i = st;
		req_valid_i = 1'b1;
		while (req_ready_o !== 1'b1) begin
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		#1 req_valid_i = 1'b0;
		lat = 1;
		while (rsp_valid_o !== 1'b1 && lat < 9) begin
			@(posedge clk_i);
			#1 lat++;
		end
		@(posedge clk_i);
		#1 check("latency", lat, 3);
	endtask : op

	task automatic t_reset;
		repeat (3) @(posedge clk_i);
		#1 check("ready in reset", req_ready_o, 1'b0);
		nrst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 check("ready after reset", req_ready_o, 1'b1);
	endtask : t_reset

	task automatic t_fill;
		op(dci_pkg::DCI_CMD_FLUSH_ALL, A);
		check("flush all", s_mnt, 5'h08);
		op(dci_pkg::DCI_CMD_READ, A);
		check("cold miss", rsp_hit_o, 1'b0);
		op(dci_pkg::DCI_CMD_FILL_LAST, A, D);
		check("fill bytes", s_lwe0, 4'hf);
		check("fill valid", {s_vwe, s_ldc, s_twe}, 6'h31);
		op(dci_pkg::DCI_CMD_READ, A);
		check("read hit", {rsp_hit_o, s_hit}, 5'h11);
		check("read data", rsp_rdata_o, D);
		check("word address", s_la, {A[17:5], A[3:2]});
		check("tag address", s_ta, A[17:5]);
		// upper half of the same line, written without closing it
		op(dci_pkg::DCI_CMD_FILL, A | 32'h0000_0010, ~D);
		check("write data", cache_write_data_o, 33'h1_edcb_a987);
		op(dci_pkg::DCI_CMD_READ, A | 32'h0000_0010);
		check("upper half", {victim_line_index_o, rsp_rdata_o}, {1'b1, ~D});
		check("delayed index", delayed_line_index_o, A[17:5]);
	endtask : t_fill

	task automatic t_write;
		op(dci_pkg::DCI_CMD_WRITE, A, 32'haaaa_bbbb, 4'h5);
		check("write strobes", {s_whe, s_whv, s_lwe0}, 9'h115);
		check("buffer address", write_hit_buffer_address_o, A[17:4]);
		check("dirty set", m.dbits[0][A[17:5]], 2'h1);
		op(dci_pkg::DCI_CMD_READ, A);
		check("merged data", rsp_rdata_o, 32'h12aa_56bb);
		op(dci_pkg::DCI_CMD_CLEAR_DIRTY, A);
		check("dirty clear", {s_mnt, m.dbits[0][A[17:5]]}, 7'h40);
		check("captured dirty", rsp_dirty_o, 2'h1);
		write_back_cfg_i = 1'b0;
		op(dci_pkg::DCI_CMD_WRITE, A, D, 4'hf);
		check("through", {write_back_policy_o, s_whe, s_whv}, 6'h10);
		check("no dirty", m.dbits[0][A[17:5]], 2'h0);
		op(dci_pkg::DCI_CMD_WRITE, B, D, 4'hf);
		check("write miss", {s_whe, s_lwe0}, 5'h00);
		write_back_cfg_i = 1'b1;
	endtask : t_write

	task automatic t_flush;
		op(dci_pkg::DCI_CMD_FLUSH_ADDR, B);
		check("flush on miss", s_mnt, 5'h00);
		op(dci_pkg::DCI_CMD_FLUSH_ADDR, A);
		check("flush on hit", s_mnt, 5'h01);
		op(dci_pkg::DCI_CMD_READ, A);
		check("flushed line", rsp_hit_o, 1'b0);
		op(dci_pkg::DCI_CMD_TAG_WRITE, A);
		check("tag write", {s_mnt, s_twe}, 9'h021);
		op(dci_pkg::DCI_CMD_READ, A);
		check("tag written", rsp_hit_o, 1'b1);
		op(dci_pkg::DCI_CMD_FLUSH_INDEX, A);
		check("flush index", s_mnt, 5'h04);
		op(dci_pkg::DCI_CMD_READ, A);
		check("index flushed", rsp_hit_o, 1'b0);
	endtask : t_flush

	// fill as many lines as there are ways, all at one index
	task automatic t_assoc;
		logic [3:0] hits;
		logic [3:0] ens;
		for (int k = 0; k < 3; k++) begin
			associativity_select_i = 2'(k);
			op(dci_pkg::DCI_CMD_FLUSH_ALL, A);
			hits = 4'h0;
			ens = 4'h0;
			for (int j = 0; j < (1 << k); j++)
				op(dci_pkg::DCI_CMD_FILL_LAST, A + (j << 20), D);
			for (int j = 0; j < (1 << k); j++) begin
				op(dci_pkg::DCI_CMD_READ, A + (j << 20));
				hits |= s_hit;
				ens |= s_en | s_ten;
			end
			check("hit sets", hits, (1 << (1 << k)) - 1);
			check("unused sets", ens & ~hits, 4'h0);
		end
	endtask : t_assoc

	task automatic t_size;
		cache_size_select_i = 4'hb;
		op(dci_pkg::DCI_CMD_READ, A);
		check("largest size", rsp_hit_o, 1'b1);
		cache_size_select_i = 4'h0;
		op(dci_pkg::DCI_CMD_READ, A);
		check("no cache", {rsp_hit_o, s_en, s_ten}, 9'h000);
	endtask : t_size

	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	// about 150 cycles of work; the limit leaves ample margin
	initial begin
		#400000;
		errors++;
		close_out();
	end

	initial begin
		t_reset();
		t_fill();
		t_write();
		t_flush();
		t_assoc();
		t_size();
		close_out();
	end
endmodule : dci_cache_ram_ctl_bench
